// ==== src/lcl_consts.svh ====
// Constants for the line current readout and loop closure block.
// Assumes inclusion by bare name from the readout module; the package does not include it.
`ifndef LCL_CONSTS_SVH
`define LCL_CONSTS_SVH

// ----------------------------------------------------------------
// RAM locations (word addresses)
// ----------------------------------------------------------------
`define LCL_ADDR_LOOP_CURRENT   8'h08
`define LCL_ADDR_TIP_POS        8'h0E
`define LCL_ADDR_RING_POS       8'h0F
`define LCL_ADDR_TIP_NEG        8'h11
`define LCL_ADDR_TIP            8'h13
`define LCL_ADDR_OFFHOOK_THR    8'h16
`define LCL_ADDR_ONHOOK_THR     8'h17
`define LCL_ADDR_DEBOUNCE       8'h18
`define LCL_ADDR_FILTER_COEF    8'h19
`define LCL_ADDR_MASK           8'h1A
`define LCL_ADDR_MASK_REVERSAL  8'hA6

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define LCL_COEF_MSB            15
`define LCL_COEF_LSB            3
`define LCL_SIGN_BIT            15
`define LCL_RESET_WORD          16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCL_CLK_PERIOD_NS       25
`define LCL_CLK_HZ              40000000
`define LCL_LOOP_RATE_HZ        800
`define LCL_MASK_STEP_NS        1250
`define LCL_LOOP_TICK_CYCLES    (`LCL_CLK_HZ / `LCL_LOOP_RATE_HZ)
`define LCL_MASK_TICK_CYCLES    (`LCL_MASK_STEP_NS / `LCL_CLK_PERIOD_NS)

`endif

// ==== src/lcl_pkg.sv ====
// Types for the line current readout and loop closure block.
// Assumes nothing beyond the constants header.
package lcl_pkg;

  typedef logic [15:0] lcl_word_t;

  typedef enum logic [1:0] {
    LCL_ONHOOK  = 2'b01,
    LCL_OFFHOOK = 2'b10
  } lcl_hook_e;

endpackage

// ==== src/lcl_timer.sv ====
// Interval timer: loads a count, steps down on each tick, busy while nonzero.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/1ps
`default_nettype none

module lcl_timer
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [15:0] load,
  input  wire logic        tick,
  output var  logic        busy
);

  logic [15:0] count;
  logic [15:0] next_count;

  always_comb
  begin
    next_count = count;
    if (start)
    begin
      next_count = load;
    end
    else if (tick && (count != 16'h0000))
    begin
      next_count = count - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= 16'h0000;
      busy  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy  <= (next_count != 16'h0000);
    end
  end

endmodule

`default_nettype wire

// ==== src/lcl_readout.sv ====
// Transistor current readout and loop closure detection with its RAM locations.
// Assumes the control interface decodes host RAM accesses onto the ram_* port and
// that the front end delivers samples on this clock.
//
// Notes on behaviour
// RULE_01: Tip-side positive transistor current kept as 16-bit two's complement, 3.097 uA/LSB.
// RULE_02: Ring-side positive transistor current kept as 16-bit two's complement, 3.097 uA/LSB.
// RULE_03: Tip transistor current kept as 16-bit two's complement, 3.097 uA/LSB.
// RULE_04: Tip-side negative transistor current kept as two's complement, 195.3 nA/LSB.
// RULE_05: Debounce interval is a full 16-bit count of 1.25 ms steps.
// RULE_06: Filter coefficient uses bits 15 to 3 only.
// RULE_07: General mask interval is 16 bits of 1.25 us steps.
// RULE_08: Separate 16-bit mask of 1.25 us steps during polarity reversal.
// RULE_09: Locations with a reset value come out of reset at zero.
// RULE_10: Off-hook on entry threshold, back on-hook at the return threshold.
// RULE_11: Loop current refreshed at 800 Hz, kept sign-magnitude.
// RULE_12: Status flips only after full debounce beyond threshold, never while masked.
// RULE_13: Reversal mask starts on reversal; general mask on linefeed state change.
`timescale 1ns/1ps
`default_nettype none
`include "lcl_consts.svh"

module lcl_readout
#(
  parameter int LOOP_TICK_CYCLES = `LCL_LOOP_TICK_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  ram_addr,
  input  wire logic        ram_wr,
  input  wire logic        ram_rd,
  input  wire logic [15:0] ram_wdata,
  output var  logic [15:0] ram_rdata,
  output var  logic        ram_rvalid,
  input  wire logic        meas_valid,
  input  wire logic [15:0] tip_pos_in,
  input  wire logic [15:0] ring_pos_in,
  input  wire logic [15:0] tip_neg_in,
  input  wire logic [15:0] tip_in,
  input  wire logic [15:0] loop_current_in,
  input  wire logic        linefeed_change,
  input  wire logic        reversal_start,
  output var  logic        loop_closed,
  output var  logic        closure_event,
  output var  logic        mask_active
);

  localparam int MASK_TICK_CYCLES = `LCL_MASK_TICK_CYCLES;

  // ----------------------------------------------------------------
  // Rate dividers
  // ----------------------------------------------------------------
  logic [15:0] loop_div;
  logic [15:0] next_loop_div;
  logic [5:0]  mask_div;
  logic [5:0]  next_mask_div;
  logic        loop_tick;
  logic        mask_tick;

  always_comb
  begin
    loop_tick     = (loop_div == 16'(LOOP_TICK_CYCLES - 1));
    mask_tick     = (mask_div == 6'(MASK_TICK_CYCLES - 1));
    next_loop_div = loop_tick ? 16'h0000 : loop_div + 16'h0001; // RULE_11
    next_mask_div = mask_tick ? 6'h00 : mask_div + 6'h01;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loop_div <= 16'h0000;
      mask_div <= 6'h00;
    end
    else
    begin
      loop_div <= next_loop_div;
      mask_div <= next_mask_div;
    end
  end

  // ----------------------------------------------------------------
  // RAM locations
  // ----------------------------------------------------------------
  lcl_pkg::lcl_word_t tip_pos_current_meas;
  lcl_pkg::lcl_word_t ring_pos_current_meas;
  lcl_pkg::lcl_word_t tip_neg_current_meas;
  lcl_pkg::lcl_word_t tip_current_meas;
  lcl_pkg::lcl_word_t loop_current_value;
  lcl_pkg::lcl_word_t offhook_entry_threshold;
  lcl_pkg::lcl_word_t onhook_return_threshold;
  lcl_pkg::lcl_word_t closure_debounce_interval;
  logic [12:0]        closure_filter_coefficient;
  lcl_pkg::lcl_word_t closure_mask_interval;
  lcl_pkg::lcl_word_t closure_mask_reversal;

  lcl_pkg::lcl_word_t next_tip_pos, next_ring_pos, next_tip_neg, next_tip;
  lcl_pkg::lcl_word_t next_loop_cur, next_offhook_thr, next_onhook_thr;
  lcl_pkg::lcl_word_t next_debounce, next_mask, next_mask_rev;
  logic [12:0]        next_coef;
  lcl_pkg::lcl_word_t next_rdata;

  // Hardware updates win over a host write in the same cycle: a fresh sample is newer
  always_comb
  begin
    next_tip_pos     = tip_pos_current_meas;
    next_ring_pos    = ring_pos_current_meas;
    next_tip_neg     = tip_neg_current_meas;
    next_tip         = tip_current_meas;
    next_loop_cur    = loop_current_value;
    next_offhook_thr = offhook_entry_threshold;
    next_onhook_thr  = onhook_return_threshold;
    next_debounce    = closure_debounce_interval;
    next_coef        = closure_filter_coefficient;
    next_mask        = closure_mask_interval;
    next_mask_rev    = closure_mask_reversal;
    if (ram_wr)
    begin
      unique case (ram_addr)
        `LCL_ADDR_TIP_POS:       next_tip_pos     = ram_wdata;
        `LCL_ADDR_RING_POS:      next_ring_pos    = ram_wdata;
        `LCL_ADDR_TIP_NEG:       next_tip_neg     = ram_wdata;
        `LCL_ADDR_TIP:           next_tip         = ram_wdata;
        `LCL_ADDR_LOOP_CURRENT:  next_loop_cur    = ram_wdata;
        `LCL_ADDR_OFFHOOK_THR:   next_offhook_thr = ram_wdata;
        `LCL_ADDR_ONHOOK_THR:    next_onhook_thr  = ram_wdata;
        `LCL_ADDR_DEBOUNCE:      next_debounce    = ram_wdata; // RULE_05
        `LCL_ADDR_FILTER_COEF:   next_coef = ram_wdata[`LCL_COEF_MSB:`LCL_COEF_LSB]; // RULE_06
        `LCL_ADDR_MASK:          next_mask        = ram_wdata; // RULE_07
        `LCL_ADDR_MASK_REVERSAL: next_mask_rev    = ram_wdata; // RULE_08
        default:                 ; // Unmapped writes dropped
      endcase
    end
    if (meas_valid)
    begin
      next_tip_pos  = tip_pos_in;  // RULE_01
      next_ring_pos = ring_pos_in; // RULE_02
      next_tip      = tip_in;      // RULE_03
      next_tip_neg  = tip_neg_in;  // RULE_04
    end
    if (loop_tick)
    begin
      next_loop_cur = loop_current_in; // RULE_11
    end
    next_rdata = 16'h0000;
    unique case (ram_addr)
      `LCL_ADDR_TIP_POS:       next_rdata = tip_pos_current_meas;
      `LCL_ADDR_RING_POS:      next_rdata = ring_pos_current_meas;
      `LCL_ADDR_TIP_NEG:       next_rdata = tip_neg_current_meas;
      `LCL_ADDR_TIP:           next_rdata = tip_current_meas;
      `LCL_ADDR_LOOP_CURRENT:  next_rdata = loop_current_value;
      `LCL_ADDR_OFFHOOK_THR:   next_rdata = offhook_entry_threshold;
      `LCL_ADDR_ONHOOK_THR:    next_rdata = onhook_return_threshold;
      `LCL_ADDR_DEBOUNCE:      next_rdata = closure_debounce_interval;
      `LCL_ADDR_FILTER_COEF:   next_rdata = {closure_filter_coefficient, 3'h0};
      `LCL_ADDR_MASK:          next_rdata = closure_mask_interval;
      `LCL_ADDR_MASK_REVERSAL: next_rdata = closure_mask_reversal;
      default:                 next_rdata = 16'h0000;
    endcase
  end

  // Every location clears to zero, including those with no printed reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tip_pos_current_meas       <= `LCL_RESET_WORD; // RULE_09
      ring_pos_current_meas      <= `LCL_RESET_WORD;
      tip_neg_current_meas       <= `LCL_RESET_WORD;
      tip_current_meas           <= `LCL_RESET_WORD;
      loop_current_value         <= `LCL_RESET_WORD;
      offhook_entry_threshold    <= `LCL_RESET_WORD;
      onhook_return_threshold    <= `LCL_RESET_WORD;
      closure_debounce_interval  <= `LCL_RESET_WORD;
      closure_filter_coefficient <= 13'h0000;
      closure_mask_interval      <= `LCL_RESET_WORD;
      closure_mask_reversal      <= `LCL_RESET_WORD;
      ram_rdata                  <= 16'h0000;
      ram_rvalid                 <= 1'b0;
    end
    else
    begin
      tip_pos_current_meas       <= next_tip_pos;
      ring_pos_current_meas      <= next_ring_pos;
      tip_neg_current_meas       <= next_tip_neg;
      tip_current_meas           <= next_tip;
      loop_current_value         <= next_loop_cur;
      offhook_entry_threshold    <= next_offhook_thr;
      onhook_return_threshold    <= next_onhook_thr;
      closure_debounce_interval  <= next_debounce;
      closure_filter_coefficient <= next_coef;
      closure_mask_interval      <= next_mask;
      closure_mask_reversal      <= next_mask_rev;
      ram_rdata                  <= ram_rd ? next_rdata : ram_rdata;
      ram_rvalid                 <= ram_rd;
    end
  end

  // ----------------------------------------------------------------
  // Mask timers
  // ----------------------------------------------------------------
  logic mask_gen_busy;
  logic mask_rev_busy;

  lcl_timer u_mask_general
  (
    .clk   (clk),
    .rstn  (rstn),
    .start (linefeed_change), // RULE_13
    .load  (closure_mask_interval),
    .tick  (mask_tick),
    .busy  (mask_gen_busy)
  );

  lcl_timer u_mask_reversal
  (
    .clk   (clk),
    .rstn  (rstn),
    .start (reversal_start), // RULE_13
    .load  (closure_mask_reversal),
    .tick  (mask_tick),
    .busy  (mask_rev_busy)
  );

  // ----------------------------------------------------------------
  // Filter, hysteresis and debounce
  // ----------------------------------------------------------------
  logic [15:0]        filt;
  logic [15:0]        next_filt;
  logic [15:0]        dbc;
  logic [15:0]        next_dbc;
  lcl_pkg::lcl_hook_e hook;
  lcl_pkg::lcl_hook_e next_hook;
  logic               next_event;
  logic               beyond;
  logic               masked;
  logic signed [16:0] diff;
  logic signed [33:0] prod;

  // First-order low-pass on magnitude; sign dropped since hook state needs |I| only
  always_comb
  begin
    diff       = $signed({2'b00, loop_current_value[14:0]}) - $signed({1'b0, filt});
    prod       = diff * $signed({1'b0, closure_filter_coefficient, 3'h0}); // RULE_06
    next_filt  = loop_tick ? filt + prod[31:16] : filt;
    masked     = mask_gen_busy || mask_rev_busy;
    next_hook  = hook;
    next_dbc   = dbc;
    next_event = 1'b0;
    unique case (hook)
      lcl_pkg::LCL_ONHOOK:  beyond = (filt > offhook_entry_threshold); // RULE_10
      lcl_pkg::LCL_OFFHOOK: beyond = (filt < onhook_return_threshold); // RULE_10
      default:              beyond = 1'b0;
    endcase
    if (masked || !beyond)
    begin
      next_dbc = 16'h0000; // RULE_12
    end
    else if (dbc >= closure_debounce_interval)
    begin
      next_hook  = (hook == lcl_pkg::LCL_ONHOOK) ? lcl_pkg::LCL_OFFHOOK : lcl_pkg::LCL_ONHOOK; // RULE_12
      next_dbc   = 16'h0000;
      next_event = 1'b1;
    end
    else if (loop_tick)
    begin
      next_dbc = dbc + 16'h0001; // RULE_05
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      filt          <= 16'h0000;
      dbc           <= 16'h0000;
      hook          <= lcl_pkg::LCL_ONHOOK;
      loop_closed   <= 1'b0;
      closure_event <= 1'b0;
      mask_active   <= 1'b0;
    end
    else
    begin
      filt          <= next_filt;
      dbc           <= next_dbc;
      hook          <= next_hook;
      loop_closed   <= (next_hook == lcl_pkg::LCL_OFFHOOK);
      closure_event <= next_event;
      mask_active   <= masked;
    end
  end

endmodule

`default_nettype wire

// ==== tb/lcl_readout_monitor.sv ====
// Checker for the readout block, watching its ports only.
// Assumes the bind at the foot reaches every lcl_readout instance.
`timescale 1ns/1ps
`default_nettype none

module lcl_readout_monitor
#(
  parameter int LOOP_TICK_CYCLES = 50000
)
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  ram_addr,
  input wire logic        ram_wr,
  input wire logic        ram_rd,
  input wire logic [15:0] ram_wdata,
  input wire logic [15:0] ram_rdata,
  input wire logic        ram_rvalid,
  input wire logic        linefeed_change,
  input wire logic        reversal_start,
  input wire logic        loop_closed,
  input wire logic        closure_event,
  input wire logic        mask_active
);
  logic [15:0] dbi_m;
  logic [15:0] coef_m;
  logic [15:0] mask_m;
  logic [15:0] rev_m;
  logic [15:0] next_dbi_m;
  logic [15:0] next_coef_m;
  logic [15:0] next_mask_m;
  logic [15:0] next_rev_m;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Shadow of host writes, so reads can be judged without the body
  always_comb
  begin
    next_dbi_m  = (ram_wr && ram_addr == 8'h18) ? ram_wdata : dbi_m;
    next_coef_m = (ram_wr && ram_addr == 8'h19) ? ram_wdata : coef_m;
    next_mask_m = (ram_wr && ram_addr == 8'h1A) ? ram_wdata : mask_m;
    next_rev_m  = (ram_wr && ram_addr == 8'hA6) ? ram_wdata : rev_m;
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      dbi_m  <= 16'h0000;
      coef_m <= 16'h0000;
      mask_m <= 16'h0000;
      rev_m  <= 16'h0000;
    end
    else
    begin
      dbi_m  <= next_dbi_m;
      coef_m <= next_coef_m;
      mask_m <= next_mask_m;
      rev_m  <= next_rev_m;
    end

  AST_RVALID: assert property (ram_rd |=> ram_rvalid)
    else $error("read not answered");
  AST_NO_RVALID: assert property (!ram_rd |=> !ram_rvalid)
    else $error("stray read valid");
  AST_RDATA_HOLD: assert property (!ram_rd |=> $stable(ram_rdata))
    else $error("read data moved without a read");
  AST_DBI_READ: assert property (ram_rd && !ram_wr && ram_addr == 8'h18 |=> ram_rdata == dbi_m)
    else $error("debounce readback wrong");
  AST_COEF_READ: assert property (ram_rd && !ram_wr && ram_addr == 8'h19 |=> ram_rdata == {coef_m[15:3], 3'h0})
    else $error("coefficient readback wrong");
  AST_UNMAPPED: assert property (ram_rd && ram_addr == 8'h20 |=> ram_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_EVENT_TOGGLE: assert property (closure_event == (loop_closed != $past(loop_closed)))
    else $error("closure event not tied to status change");
  AST_RESET_OUT: assert property ($rose(rstn) |-> !loop_closed && !closure_event && !mask_active)
    else $error("outputs not clear after reset");
  AST_MASK_START: assert property (linefeed_change && mask_m != 16'h0000 |-> ##[1:2] mask_active)
    else $error("general mask did not start");
  AST_REV_START: assert property (reversal_start && rev_m != 16'h0000 |-> ##[1:2] mask_active)
    else $error("reversal mask did not start");

  COV_CLOSE: cover property ($rose(loop_closed));
  COV_OPEN: cover property ($fell(loop_closed));
  COV_MASK_END: cover property (mask_active ##1 !mask_active);
endmodule

bind lcl_readout lcl_readout_monitor #(.LOOP_TICK_CYCLES(LOOP_TICK_CYCLES)) u_lcl_readout_monitor
(
  .clk             (clk),
  .rstn            (rstn),
  .ram_addr        (ram_addr),
  .ram_wr          (ram_wr),
  .ram_rd          (ram_rd),
  .ram_wdata       (ram_wdata),
  .ram_rdata       (ram_rdata),
  .ram_rvalid      (ram_rvalid),
  .linefeed_change (linefeed_change),
  .reversal_start  (reversal_start),
  .loop_closed     (loop_closed),
  .closure_event   (closure_event),
  .mask_active     (mask_active)
);

`default_nettype wire

// ==== tb/lcl_host.sv ====
// Host model: single-word RAM reads and writes on the control port.
// Assumes the caller waits for read data on ram_rvalid itself.
`timescale 1ns/1ps
`default_nettype none

module lcl_host
(
  input  wire logic        clk,
  output var  logic [7:0]  ram_addr,
  output var  logic        ram_wr,
  output var  logic        ram_rd,
  output var  logic [15:0] ram_wdata
);
  // Idle bus carries a changing pattern, never a stale address
  initial
  begin
    ram_addr  = 8'hFF;
    ram_wr    = 1'b0;
    ram_rd    = 1'b0;
    ram_wdata = 16'hA5A5;
  end

  task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    ram_addr  = a;
    ram_wdata = d;
    ram_wr    = w;
    ram_rd    = !w;
    @(posedge clk);
    #1;
    ram_wr    = 1'b0;
    ram_rd    = 1'b0;
    ram_addr  = ~a;
    ram_wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the readout block.
// Assumes a short loop tick so detection runs in under a hundred cycles.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int TICK = 20;
  logic clk;
  logic rstn;
  logic [7:0]  ram_addr;
  logic        ram_wr;
  logic        ram_rd;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic        ram_rvalid;
  logic        meas_valid;
  logic [15:0] meas [4];
  logic [15:0] loop_current_in;
  logic        linefeed_change;
  logic        reversal_start;
  logic        loop_closed;
  logic        closure_event;
  logic        mask_active;
  logic [15:0] exp_q [$];
  logic [15:0] v;
  int          error_cnt;
  int          num_checks;
  int          i;
  int          n;
  logic [7:0]  reg_a [12] = '{8'h0E, 8'h0F, 8'h11, 8'h13, 8'h18, 8'h19, 8'h1A, 8'hA6, 8'h08, 8'h16, 8'h17, 8'h20};

  lcl_readout #(.LOOP_TICK_CYCLES(TICK)) u_lcl_readout (.clk(clk), .rstn(rstn), .ram_addr(ram_addr),
    .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid),
    .meas_valid(meas_valid), .tip_pos_in(meas[0]), .ring_pos_in(meas[1]), .tip_neg_in(meas[2]),
    .tip_in(meas[3]), .loop_current_in(loop_current_in), .linefeed_change(linefeed_change),
    .reversal_start(reversal_start), .loop_closed(loop_closed), .closure_event(closure_event),
    .mask_active(mask_active));
  lcl_host u_lcl_host (.clk(clk), .ram_addr(ram_addr), .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_wdata(ram_wdata));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_lcl_host.op(1'b0, a, 16'h0000);
  endtask

  // Bounded wait for the hook status; a hang ends the run
  task automatic wait_lvl(input logic lvl, input int bound);
    n = 0;
    while (loop_closed !== lvl && n < bound)
    begin
      @(negedge clk);
      n++;
    end
    if (loop_closed !== lvl)
    begin
      error_cnt++;
      $display("ERROR loop_closed wait ran out");
      stop_test();
    end
    check("closure_event", {15'h0000, closure_event}, 16'h0001);
  endtask

  // Read results arrive one cycle after the strobe, oldest note first
  always @(negedge clk)
    if (ram_rvalid === 1'b1)
      check("ram_rdata", ram_rdata, exp_q.pop_front());

  initial
  begin
    rstn = 1'b0;
    meas_valid = 1'b0;
    meas = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    loop_current_in = 16'h0000;
    linefeed_change = 1'b0;
    reversal_start = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    v = 16'($urandom(48868));
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    for (i = 0; i < 12; i++)
      rd(reg_a[i], 16'h0000);
    for (i = 4; i < 8; i++)
    begin
      v = (i == 4) ? 16'hFFFF : 16'($urandom);
      u_lcl_host.op(1'b1, reg_a[i], v);
      rd(reg_a[i], (i == 5) ? (v & 16'hFFF8) : v);
    end
    u_lcl_host.op(1'b1, 8'h20, 16'hFFFF);
    rd(8'h20, 16'h0000);
    // Negative and random samples, both scales
    @(posedge clk);
    #1;
    for (i = 0; i < 4; i++)
      meas[i] = (i == 2) ? 16'h8001 : 16'($urandom);
    meas_valid = 1'b1;
    @(posedge clk);
    #1 meas_valid = 1'b0;
    for (i = 0; i < 4; i++)
      rd(reg_a[i], meas[i]);
    // Detection: thresholds 100/50, debounce two ticks, no masks
    u_lcl_host.op(1'b1, 8'h1A, 16'h0000);
    u_lcl_host.op(1'b1, 8'hA6, 16'h0000);
    u_lcl_host.op(1'b1, 8'h19, 16'hFFF8);
    u_lcl_host.op(1'b1, 8'h16, 16'h0064);
    u_lcl_host.op(1'b1, 8'h17, 16'h0032);
    u_lcl_host.op(1'b1, 8'h18, 16'h0002);
    @(posedge clk);
    #1 loop_current_in = 16'h83E8;
    wait_lvl(1'b1, 200);
    // Sample tick, filter tick, then two debounce ticks, tick phase unknown
    check("debounce_wait", 16'(n >= 3 * TICK + 3 && n <= 4 * TICK + 2), 16'h0001);
    rd(8'h08, 16'h83E8);
    // Masks of four steps hold the status through a current change
    for (i = 0; i < 2; i++)
    begin
      u_lcl_host.op(1'b1, (i == 1) ? 8'hA6 : 8'h1A, 16'h0004);
      @(posedge clk);
      #1;
      reversal_start = (i == 1);
      linefeed_change = (i == 0);
      loop_current_in = (i == 1) ? 16'h03E8 : 16'h0000;
      @(posedge clk);
      #1;
      reversal_start = 1'b0;
      linefeed_change = 1'b0;
      repeat (150)
      begin
        @(negedge clk);
        check("loop_closed_masked", {15'h0000, loop_closed}, {15'h0000, i == 0});
      end
      check("mask_active_on", {15'h0000, mask_active}, 16'h0001);
      wait_lvl(i == 1, 400);
      check("mask_active_off", {15'h0000, mask_active}, 16'h0000);
    end
    repeat (4) @(posedge clk);
    check("exp_q_empty", 16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule

`default_nettype wire
